/* hw/ofc_defs.svh */
// register addresses, field positions, reset values and decode constants
// assumes inclusion by the register module and by the bench
`ifndef OFC_DEFS_SVH
`define OFC_DEFS_SVH
`define OFC_ADDR_SEP_GAIN    8'h20
`define OFC_ADDR_PRI_GAIN    8'h21
`define OFC_ADDR_LED_CURRENT 8'h22
`define OFC_ADDR_PWR_CLOCK   8'h23
`define OFC_RESET_WORD       24'h000000
`define OFC_SPLIT_BIT        15
`define OFC_CAP_HI           5
`define OFC_CAP_LO           3
`define OFC_GAIN_HI          2
`define OFC_GAIN_LO          0
`define OFC_LED3_HI          17
`define OFC_LED3_LO          12
`define OFC_LED2_HI          11
`define OFC_LED2_LO          6
`define OFC_LED1_HI          5
`define OFC_LED1_LO          0
`define OFC_LED_WIDTH        6
`define OFC_LED_COUNT        3
`define OFC_SEP_MASK         24'h00803F
`define OFC_PRI_MASK         24'h00003F
`define OFC_LED_MASK         24'h03FFFF
`define OFC_PWR_MASK         24'h12421B
`define OFC_BIT_DYN_TX       20
`define OFC_BIT_RANGE2X      17
`define OFC_BIT_DYN_ADC      14
`define OFC_BIT_OSC          9
`define OFC_BIT_DYN_TIA      4
`define OFC_BIT_DYN_REST     3
`define OFC_BIT_RX_PD        1
`define OFC_BIT_FULL_PD      0
`define OFC_STEP_UA          17'h00320
`define OFC_STEP_2X_UA       17'h00640
`endif

/* hw/ofc_pkg.sv */
// types shared by the optical front end control registers
// assumes ofc_defs.svh is on the include path
package ofc_pkg;
  typedef logic [23:0] ofc_word_type;
  typedef logic [7:0]  ofc_addr_type;
  typedef logic [2:0]  ofc_code_type;
  typedef logic [5:0]  ofc_led_code_type;
  typedef logic [21:0] ofc_ohm_type;      // feedback resistance in ohms
  typedef logic [7:0]  ofc_cap_type;      // feedback capacitance in 0.1 pF
  typedef logic [16:0] ofc_ua_type;       // led current in microamps
endpackage : ofc_pkg

/* hw/ofc_regs.sv */
// control registers of an optical front end: gain, led current, power and clock
// assumes a serial engine ahead of it that delivers whole-word reads and writes
// Overview of operation
// - decode 3-bit gain code into 500k,250k,100k,50k,25k,10k,1M,2M ohms.
// - decode 3-bit capacitor code into 5,2.5,10,7.5,20,17.5,25,22.5 pF.
// - split enable clear: primary codes drive both sets; set: separate codes second.
// - led register holds three 6-bit codes at 17-12, 11-6, 5-0, read/write.
// - led code maps linearly, 0.8 mA per count, 63 gives 50.4 mA.
// - power register bit 17 doubles led full scale to 100.8 mA.
// - bit 20 powers down transmitter during dynamic power-down.
// - bit 14 powers down the ADC during dynamic power-down.
// - bit 4 powers down the transimpedance amplifier during dynamic power-down.
// - bit 3 powers down remaining ADC circuitry during dynamic power-down.
// - bit 9 selects internal 4 MHz oscillator; clear means external clock input.
// - bit 1 powers down the receive section.
// - bit 0 powers down the entire front end.
// - led current register at 22h resets to zero.
// - power and clock register at 23h resets to zero.
`timescale 1ns/1ps
`include "ofc_defs.svh"
module ofc_regs
  import ofc_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire ofc_pkg::ofc_addr_type reg_addr,
  input  wire ofc_pkg::ofc_word_type reg_wdata,
  input  wire logic             reg_write,
  input  wire logic             reg_read,
  input  wire logic             dyn_pd_phase,
  output ofc_pkg::ofc_word_type reg_rdata,
  output ofc_pkg::ofc_ohm_type  rf1_ohm,
  output ofc_pkg::ofc_cap_type  cf1_tenth_pf,
  output ofc_pkg::ofc_ohm_type  rf2_ohm,
  output ofc_pkg::ofc_cap_type  cf2_tenth_pf,
  output ofc_pkg::ofc_ua_type   led1_current_ua,
  output ofc_pkg::ofc_ua_type   led2_current_ua,
  output ofc_pkg::ofc_ua_type   led3_current_ua,
  output logic                  tx_off,
  output logic                  adc_off,
  output logic                  tia_off,
  output logic                  adc_rest_off,
  output logic                  rx_off,
  output logic                  front_end_off,
  output logic                  internal_osc_on,
  output logic                  clk_pin_is_input
);
  import ofc_pkg::*;

  ofc_word_type sep_gain;
  ofc_word_type pri_gain;
  ofc_word_type led_drive_current;
  ofc_word_type power_clock_control;
  ofc_ua_type   led_next_ua [`OFC_LED_COUNT];

  function automatic ofc_ohm_type gain_ohm(input ofc_code_type code);
    case (code)
      3'h0:    gain_ohm = 22'd500000;
      3'h1:    gain_ohm = 22'd250000;
      3'h2:    gain_ohm = 22'd100000;
      3'h3:    gain_ohm = 22'd50000;
      3'h4:    gain_ohm = 22'd25000;
      3'h5:    gain_ohm = 22'd10000;
      3'h6:    gain_ohm = 22'd1000000;
      default: gain_ohm = 22'd2000000;
    endcase
  endfunction : gain_ohm

  function automatic ofc_cap_type cap_tenth(input ofc_code_type code);
    case (code)
      3'h0:    cap_tenth = 8'd50;
      3'h1:    cap_tenth = 8'd25;
      3'h2:    cap_tenth = 8'd100;
      3'h3:    cap_tenth = 8'd75;
      3'h4:    cap_tenth = 8'd200;
      3'h5:    cap_tenth = 8'd175;
      3'h6:    cap_tenth = 8'd250;
      default: cap_tenth = 8'd225;
    endcase
  endfunction : cap_tenth

  // register writes; reserved bits are masked off so they always read zero,
  // which keeps the device safe even when a host ignores the must-write-zero duty
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sep_gain            <= `OFC_RESET_WORD;
      pri_gain            <= `OFC_RESET_WORD;
      led_drive_current   <= `OFC_RESET_WORD;
      power_clock_control <= `OFC_RESET_WORD;
    end
    else if (reg_write)
    begin
      if (reg_addr == `OFC_ADDR_SEP_GAIN)
        sep_gain <= reg_wdata & `OFC_SEP_MASK;
      else if (reg_addr == `OFC_ADDR_PRI_GAIN)
        pri_gain <= reg_wdata & `OFC_PRI_MASK;
      else if (reg_addr == `OFC_ADDR_LED_CURRENT)
        led_drive_current <= reg_wdata & `OFC_LED_MASK;
      else if (reg_addr == `OFC_ADDR_PWR_CLOCK)
        power_clock_control <= reg_wdata & `OFC_PWR_MASK;
    end
  end

  // read data, one cycle after the strobe; unmapped addresses read zero
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= `OFC_RESET_WORD;
    else if (reg_read)
    begin
      if (reg_addr == `OFC_ADDR_SEP_GAIN)
        reg_rdata <= sep_gain;
      else if (reg_addr == `OFC_ADDR_PRI_GAIN)
        reg_rdata <= pri_gain;
      else if (reg_addr == `OFC_ADDR_LED_CURRENT)
        reg_rdata <= led_drive_current;
      else if (reg_addr == `OFC_ADDR_PWR_CLOCK)
        reg_rdata <= power_clock_control;
      else
        reg_rdata <= `OFC_RESET_WORD;
    end
  end

  // feedback set selection; outputs lag the register by one cycle
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rf1_ohm      <= 22'd0;
      cf1_tenth_pf <= 8'd0;
      rf2_ohm      <= 22'd0;
      cf2_tenth_pf <= 8'd0;
    end
    else
    begin
      rf1_ohm      <= gain_ohm(pri_gain[`OFC_GAIN_HI:`OFC_GAIN_LO]);
      cf1_tenth_pf <= cap_tenth(pri_gain[`OFC_CAP_HI:`OFC_CAP_LO]);
      if (sep_gain[`OFC_SPLIT_BIT])
      begin
        rf2_ohm      <= gain_ohm(sep_gain[`OFC_GAIN_HI:`OFC_GAIN_LO]);
        cf2_tenth_pf <= cap_tenth(sep_gain[`OFC_CAP_HI:`OFC_CAP_LO]);
      end
      else
      begin
        rf2_ohm      <= gain_ohm(pri_gain[`OFC_GAIN_HI:`OFC_GAIN_LO]);
        cf2_tenth_pf <= cap_tenth(pri_gain[`OFC_CAP_HI:`OFC_CAP_LO]);
      end
    end
  end

  // led current: fixed step per count, step doubled in the wide range;
  // code 63 gives 50.4 mA, the nominal 50 mA full scale rounded by the step
  wire ofc_ua_type step_ua = power_clock_control[`OFC_BIT_RANGE2X] ?
                             `OFC_STEP_2X_UA : `OFC_STEP_UA;

  // one multiplier per led field, field i sits at bits 6*i upward
  for (genvar i = 0; i < `OFC_LED_COUNT; i++)
  begin : g_led
    assign led_next_ua[i] =
      17'(led_drive_current[i * `OFC_LED_WIDTH +: `OFC_LED_WIDTH] * step_ua);
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      led1_current_ua <= 17'd0;
      led2_current_ua <= 17'd0;
      led3_current_ua <= 17'd0;
    end
    else
    begin
      led1_current_ua <= led_next_ua[0];
      led2_current_ua <= led_next_ua[1];
      led3_current_ua <= led_next_ua[2];
    end
  end

  // power and clock controls; full power-down overrides every other power-down output, not the clock select
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_off           <= 1'b0;
      adc_off          <= 1'b0;
      tia_off          <= 1'b0;
      adc_rest_off     <= 1'b0;
      rx_off           <= 1'b0;
      front_end_off    <= 1'b0;
      internal_osc_on  <= 1'b0;
      clk_pin_is_input <= 1'b1;
    end
    else
    begin
      front_end_off <= power_clock_control[`OFC_BIT_FULL_PD];
      rx_off        <= power_clock_control[`OFC_BIT_FULL_PD] |
                       power_clock_control[`OFC_BIT_RX_PD];
      tx_off        <= power_clock_control[`OFC_BIT_FULL_PD] |
                       (dyn_pd_phase & power_clock_control[`OFC_BIT_DYN_TX]);
      adc_off       <= power_clock_control[`OFC_BIT_FULL_PD] |
                       (dyn_pd_phase & power_clock_control[`OFC_BIT_DYN_ADC]);
      tia_off       <= power_clock_control[`OFC_BIT_FULL_PD] |
                       (dyn_pd_phase & power_clock_control[`OFC_BIT_DYN_TIA]);
      adc_rest_off  <= power_clock_control[`OFC_BIT_FULL_PD] |
                       (dyn_pd_phase & power_clock_control[`OFC_BIT_DYN_REST]);
      internal_osc_on  <= power_clock_control[`OFC_BIT_OSC];
      clk_pin_is_input <= ~power_clock_control[`OFC_BIT_OSC];
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  gain_decode_a: assert property (
    pri_gain[2:0] == 3'h6 |=> rf1_ohm == 22'd1000000)
    else $error("gain code 6 not decoded as 1M");
  cap_decode_a: assert property (
    pri_gain[5:3] == 3'h1 |=> cf1_tenth_pf == 8'd25)
    else $error("cap code 1 not decoded as 2.5 pF");
  shared_set_a: assert property (
    !sep_gain[15] |=> rf2_ohm == rf1_ohm && cf2_tenth_pf == cf1_tenth_pf)
    else $error("second set differs with split gain off");
  led_write_a: assert property (
    reg_write && reg_addr == 8'h22 ##1 reg_read && reg_addr == 8'h22 |=>
      reg_rdata == ($past(reg_wdata, 2) & 24'h03FFFF))
    else $error("led register readback mismatch");
  led_step_a: assert property (
    !power_clock_control[17] |=> led1_current_ua == 17'($past(led_drive_current[5:0]) * 800))
    else $error("led1 current not 0.8 mA per count");
  led_range_a: assert property (
    power_clock_control[17] && led_drive_current[17:12] == 6'h3F |=>
      led3_current_ua == 17'd100800)
    else $error("doubled range full scale wrong");
  tx_dynamic_a: assert property (
    dyn_pd_phase && power_clock_control[20] |=> tx_off)
    else $error("transmitter not powered down");
  adc_dynamic_a: assert property (
    !power_clock_control[0] && !(dyn_pd_phase && power_clock_control[14]) |=> !adc_off)
    else $error("adc powered down without cause");
  tia_dynamic_a: assert property (
    dyn_pd_phase && power_clock_control[4] |=> tia_off)
    else $error("tia not powered down");
  rest_dynamic_a: assert property (
    dyn_pd_phase && power_clock_control[3] |=> adc_rest_off)
    else $error("rest of adc not powered down");
  osc_select_a: assert property (
    ##1 internal_osc_on == !clk_pin_is_input && internal_osc_on == $past(power_clock_control[9]))
    else $error("clock source select wrong");
  rx_power_a: assert property (
    power_clock_control[1] |=> rx_off)
    else $error("receive section not powered down");
  full_power_a: assert property (
    power_clock_control[0] |=> front_end_off && tx_off && adc_off && tia_off && rx_off)
    else $error("full power-down incomplete");
  reserved_zero_a: assert property (
    (led_drive_current & ~24'h03FFFF) == 24'h0 && (power_clock_control & ~24'h12421B) == 24'h0)
    else $error("reserved bits hold ones");

  split_gain_c: cover property (sep_gain[15] && rf2_ohm != rf1_ohm);
  led_double_c: cover property (power_clock_control[17] && led1_current_ua != 17'd0);
  full_down_c:  cover property (front_end_off ##1 !front_end_off);
endmodule : ofc_regs

/* bench/ofc_regs_tb.sv */
// self-checking bench for the optical front end control registers
// assumes ofc_pkg compiled first and ofc_defs.svh on the include path
`timescale 1ns/1ps
`include "ofc_defs.svh"
module ofc_regs_tb;
  import ofc_pkg::*;
  logic         ref_clk, rstn, reg_write, reg_read, dyn_pd_phase;
  ofc_addr_type reg_addr;
  ofc_word_type reg_wdata, reg_rdata;
  ofc_ohm_type  rf1_ohm, rf2_ohm;
  ofc_cap_type  cf1_tenth_pf, cf2_tenth_pf;
  ofc_ua_type   led1_current_ua, led2_current_ua, led3_current_ua;
  logic         tx_off, adc_off, tia_off, adc_rest_off, rx_off, front_end_off;
  logic         internal_osc_on, clk_pin_is_input;
  int           num_errors, n_compared;
  int           ohm_tab [8] = '{500000, 250000, 100000, 50000, 25000, 10000, 1000000, 2000000};
  int           cap_tab [8] = '{50, 25, 100, 75, 200, 175, 250, 225};
  int           pbits [7]   = '{20, 14, 4, 3, 1, 0, 9};

  ofc_regs i_dut (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .dyn_pd_phase(dyn_pd_phase),
    .reg_rdata(reg_rdata), .rf1_ohm(rf1_ohm), .cf1_tenth_pf(cf1_tenth_pf), .rf2_ohm(rf2_ohm),
    .cf2_tenth_pf(cf2_tenth_pf), .led1_current_ua(led1_current_ua),
    .led2_current_ua(led2_current_ua), .led3_current_ua(led3_current_ua), .tx_off(tx_off),
    .adc_off(adc_off), .tia_off(tia_off), .adc_rest_off(adc_rest_off), .rx_off(rx_off),
    .front_end_off(front_end_off), .internal_osc_on(internal_osc_on),
    .clk_pin_is_input(clk_pin_is_input));

  // 25 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic chk_word(input ofc_word_type got, input ofc_word_type exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_word

  // decoded values widened to the largest output, ohms
  task automatic chk_val(input logic [21:0] got, input logic [21:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask : chk_val

  task automatic chk_flags(input logic [7:0] exp, input string what);
    logic [7:0] got;
    got = {tx_off, adc_off, tia_off, adc_rest_off, rx_off, front_end_off, internal_osc_on,
           clk_pin_is_input};
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk_flags

  // write ends one cycle late so decoded outputs have settled
  task automatic wr(input ofc_addr_type a, input ofc_word_type d);
    @(negedge ref_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge ref_clk);
    reg_write = 1'b0;
    @(negedge ref_clk);
  endtask : wr

  task automatic rd(input ofc_addr_type a, input ofc_word_type exp, input string what);
    @(negedge ref_clk);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge ref_clk);
    reg_read = 1'b0;
    chk_word(reg_rdata, exp, what);
  endtask : rd

  // write then read on the very next edge; the read must see the new word
  task automatic wr_rd(input ofc_addr_type a, input ofc_word_type d, input ofc_word_type exp,
                       input string what);
    @(negedge ref_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge ref_clk);
    reg_write = 1'b0;
    reg_read  = 1'b1;
    @(negedge ref_clk);
    reg_read = 1'b0;
    chk_word(reg_rdata, exp, what);
  endtask : wr_rd

  // expected power flags: full power-down overrides every dynamic bit
  function automatic logic [7:0] exp_pwr(input int b, input logic ph);
    logic full = (b == 0);
    return {full | (ph & (b == 20)), full | (ph & (b == 14)), full | (ph & (b == 4)),
            full | (ph & (b == 3)), full | (b == 1), full, b == 9, b != 9};
  endfunction : exp_pwr

  task automatic chk_leds(input int c3, input int c2, input int c1, input int step);
    chk_val(22'(led3_current_ua), 22'(c3 * step), "led3");
    chk_val(22'(led2_current_ua), 22'(c2 * step), "led2");
    chk_val(22'(led1_current_ua), 22'(c1 * step), "led1");
  endtask : chk_leds

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // watchdog well beyond the roughly 110 cycles the tests need
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    num_errors++;
    $display("BAD t=%0t watchdog expired", $time);
    stop_test();
  end

  initial
  begin
    {rstn, reg_write, reg_read, dyn_pd_phase} = 4'h0;
    reg_addr  = 8'h00;
    reg_wdata = 24'h000000;
    repeat (5) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk_flags(exp_pwr(-1, 1'b0), "reset flags");
    chk_leds(0, 0, 0, 800);
    rd(`OFC_ADDR_LED_CURRENT, 24'h000000, "led reset");
    rd(`OFC_ADDR_PWR_CLOCK, 24'h000000, "pwr reset");
    $display("test reset done");
    // shared gain: primary codes drive both sets
    for (int c = 0; c < 8; c++)
    begin
      wr(`OFC_ADDR_PRI_GAIN, 24'((7 - c) << 3 | c));
      chk_val(rf1_ohm, 22'(ohm_tab[c]), "rf1");
      chk_val(rf2_ohm, 22'(ohm_tab[c]), "rf2 shared");
      chk_val(22'(cf1_tenth_pf), 22'(cap_tab[7 - c]), "cf1");
      chk_val(22'(cf2_tenth_pf), 22'(cap_tab[7 - c]), "cf2 shared");
    end
    // split gain: separate codes take over the second set only
    wr(`OFC_ADDR_SEP_GAIN, 24'h00802B);
    chk_val(rf1_ohm, 22'(ohm_tab[7]), "rf1 split");
    chk_val(rf2_ohm, 22'(ohm_tab[3]), "rf2 split");
    chk_val(22'(cf2_tenth_pf), 22'(cap_tab[5]), "cf2 split");
    wr(`OFC_ADDR_SEP_GAIN, 24'h00002B);
    chk_val(rf2_ohm, 22'(ohm_tab[7]), "rf2 unsplit");
    $display("test gain done");
    // led codes 63, 1 and 42, then doubled range
    wr(`OFC_ADDR_LED_CURRENT, 24'h03F06A);
    rd(`OFC_ADDR_LED_CURRENT, 24'h03F06A, "led readback");
    chk_leds(63, 1, 42, 800);
    wr(`OFC_ADDR_PWR_CLOCK, 24'h020000);
    chk_leds(63, 1, 42, 1600);
    // unmapped address: write ignored, read zero
    wr(8'h24, 24'h000015);
    rd(8'h24, 24'h000000, "unmapped");
    rd(`OFC_ADDR_LED_CURRENT, 24'h03F06A, "led kept");
    wr_rd(`OFC_ADDR_LED_CURRENT, 24'h015A5A, 24'h015A5A, "led back to back");
    $display("test led done");
    // each power bit with dynamic phase on and off
    foreach (pbits[i])
    begin
      dyn_pd_phase = 1'b1;
      wr(`OFC_ADDR_PWR_CLOCK, 24'h000001 << pbits[i]);
      chk_flags(exp_pwr(pbits[i], 1'b1), "pwr phase on");
      rd(`OFC_ADDR_PWR_CLOCK, 24'h000001 << pbits[i], "pwr readback");
      dyn_pd_phase = 1'b0;
      @(negedge ref_clk);
      chk_flags(exp_pwr(pbits[i], 1'b0), "pwr phase off");
    end
    $display("test power done");
    // mid-run reset returns the led and power registers and their outputs to idle values
    rstn = 1'b0;
    @(negedge ref_clk);
    rstn = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk_flags(exp_pwr(-1, 1'b0), "flags after reset");
    chk_leds(0, 0, 0, 800);
    rd(`OFC_ADDR_LED_CURRENT, 24'h000000, "led after reset");
    rd(`OFC_ADDR_PWR_CLOCK, 24'h000000, "pwr after reset");
    $display("test mid-run reset done");
    stop_test();
  end
endmodule : ofc_regs_tb
